// ===== ssbg_baud_gen.v
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
// Functional notes
// - Counter advances at half the CPU clock.
// - Counts down, runs only while enabled.
// - One 16-bit register: reload and count.
// - Enabled read returns live count.
// - Disabled: read reload, write stores reload.
// - Rate is clock over two times reload-plus-one; reloads below three run as three.
// - Bit rate kept at or below 8 Mbaud.
`include "ssbg_regs.vh"

module ssbg_baud_gen #(
	parameter AW = 4,
	parameter DW = 16,
	parameter CPU_KHZ = `SSBG_CPU_KHZ,
	parameter MAX_BAUD_KHZ = `SSBG_MAX_BAUD_KHZ
) (
	// Clock and reset.
	input wire clk,
	input wire reset_n,
	// Register port.
	input wire [AW-1:0] reg_addr,
	input wire [DW-1:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [DW-1:0] reg_rdata,
	// Towards the shift logic.
	output wire channel_global_on,
	output reg baud_tick
);

	// The floor keeps the shift clock under the bit-rate ceiling at this clock.
	localparam integer RATE_DIV = `SSBG_STEP_DIV * MAX_BAUD_KHZ;
	localparam integer DIV_MIN = (CPU_KHZ + RATE_DIV - `SSBG_UNIT) / RATE_DIV;
	localparam integer RELOAD_MIN_I = DIV_MIN - `SSBG_UNIT;
	localparam [DW-1:0] RELOAD_MIN = RELOAD_MIN_I[DW-1:0];

	function hit;
		input [AW-1:0] addr;
		input [AW-1:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	wire run;
	wire [DW-1:0] reload_val;
	wire [DW-1:0] reload_eff;
	wire [DW-1:0] count_val;
	wire [DW-1:0] rdata_val;
	wire tick_val;
	wire ctrl_wr;
	wire baud_wr;
	wire ctrl_rd;
	wire baud_rd;

	assign ctrl_wr = reg_wr & hit(reg_addr, `SSBG_ADDR_CONTROL);
	assign baud_wr = reg_wr & hit(reg_addr, `SSBG_ADDR_BAUD);
	assign ctrl_rd = reg_rd & hit(reg_addr, `SSBG_ADDR_CONTROL);
	assign baud_rd = reg_rd & hit(reg_addr, `SSBG_ADDR_BAUD);

	// Reserved and too-fast reloads run at the floor rate, never faster.
	assign reload_eff = (reload_val < RELOAD_MIN) ? RELOAD_MIN : reload_val;
	assign channel_global_on = run;

	ssbg_ctl_regs #(
		.DW(DW)
	) i_ssbg_ctl_regs (
		.clk(clk),
		.reset_n(reset_n),
		.ctrl_wr(ctrl_wr),
		.baud_wr(baud_wr),
		.wdata(reg_wdata),
		.run(run),
		.reload(reload_val)
	);

	ssbg_down_count #(
		.DW(DW)
	) i_ssbg_down_count (
		.clk(clk),
		.reset_n(reset_n),
		.run(run),
		.reload(reload_eff),
		.count(count_val),
		.tick(tick_val)
	);

	ssbg_read_port #(
		.DW(DW)
	) i_ssbg_read_port (
		.clk(clk),
		.reset_n(reset_n),
		.ctrl_rd(ctrl_rd),
		.baud_rd(baud_rd),
		.run(run),
		.count(count_val),
		.reload(reload_val),
		.rdata(rdata_val)
	);

	always @* begin
		reg_rdata = rdata_val;
		baud_tick = tick_val;
	end

endmodule

module ssbg_ctl_regs #(
	parameter DW = 16
) (
	// Clock and reset.
	input wire clk,
	input wire reset_n,
	// Decoded writes.
	input wire ctrl_wr,
	input wire baud_wr,
	input wire [DW-1:0] wdata,
	// Stored state.
	output wire run,
	output wire [DW-1:0] reload
);

	reg on_q;
	reg on_d;
	reg [DW-1:0] reload_q;
	reg [DW-1:0] reload_d;

	assign run = on_q;
	assign reload = reload_q;

	always @* begin
		on_d = on_q;
		if (ctrl_wr) begin
			on_d = wdata[`SSBG_CTRL_ON_BIT];
		end
	end

	always @* begin
		reload_d = reload_q;
		// A write while running is dropped, so the ratio cannot change mid-frame.
		if (baud_wr && !on_q) begin
			reload_d = wdata;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			on_q <= 1'h0;
		end else begin
			on_q <= on_d;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			reload_q <= `SSBG_RELOAD_RESET;
		end else begin
			reload_q <= reload_d;
		end
	end

endmodule

module ssbg_down_count #(
	parameter DW = 16
) (
	// Clock and reset.
	input wire clk,
	input wire reset_n,
	// Control.
	input wire run,
	input wire [DW-1:0] reload,
	// Count and tick.
	output wire [DW-1:0] count,
	output wire tick
);

	localparam [DW-1:0] ZERO_W = {DW{1'h0}};
	localparam [DW-1:0] ONE_W = {{(DW-1){1'h0}}, 1'h1};

	reg half_q;
	reg half_d;
	reg [DW-1:0] count_q;
	reg [DW-1:0] count_d;
	reg tick_q;
	reg tick_d;
	wire step;
	wire at_zero;

	// Count steps only on every second CPU clock while the channel runs.
	assign step = run & half_q;
	assign at_zero = (count_q == ZERO_W);
	assign count = count_q;
	assign tick = tick_q;

	always @* begin
		half_d = 1'h0;
		if (run) begin
			half_d = ~half_q;
		end
	end

	// Stopped, the counter sits on the reload so a restart gives a full first period.
	always @* begin
		count_d = reload;
		if (run) begin
			count_d = count_q;
			if (step && at_zero) begin
				// Reload value N gives N+1 steps of two clocks per tick.
				count_d = reload;
			end else if (step) begin
				count_d = count_q - ONE_W;
			end
		end
	end

	always @* begin
		tick_d = 1'h0;
		if (step && at_zero) begin
			tick_d = 1'h1;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			half_q <= 1'h0;
		end else begin
			half_q <= half_d;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			count_q <= `SSBG_RELOAD_RESET;
		end else begin
			count_q <= count_d;
		end
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			tick_q <= 1'h0;
		end else begin
			tick_q <= tick_d;
		end
	end

endmodule

module ssbg_read_port #(
	parameter DW = 16
) (
	// Clock and reset.
	input wire clk,
	input wire reset_n,
	// Decoded reads.
	input wire ctrl_rd,
	input wire baud_rd,
	// Sources.
	input wire run,
	input wire [DW-1:0] count,
	input wire [DW-1:0] reload,
	// Read data, one cycle after the strobe.
	output wire [DW-1:0] rdata
);

	localparam [DW-1:0] ZERO_W = {DW{1'h0}};

	reg [DW-1:0] ctrl_view;
	reg [DW-1:0] rdata_q;
	reg [DW-1:0] rdata_d;
	wire [DW-1:0] baud_view;

	assign rdata = rdata_q;

	// Dual-function view: live count while running, reload while stopped.
	genvar b;
	generate
		for (b = 0; b < DW; b = b + 1) begin : g_baud_view
			assign baud_view[b] = run ? count[b] : reload[b];
		end
	endgenerate

	always @* begin
		ctrl_view = ZERO_W;
		ctrl_view[`SSBG_CTRL_ON_BIT] = run;
	end

	always @* begin
		rdata_d = ZERO_W;
		if (ctrl_rd) begin
			rdata_d = ctrl_view;
		end else if (baud_rd) begin
			rdata_d = baud_view;
		end
	end

	// Read data stand for one cycle only, so a stale value is never mistaken.
	always @(posedge clk) begin
		if (!reset_n) begin
			rdata_q <= ZERO_W;
		end else begin
			rdata_q <= rdata_d;
		end
	end

endmodule

// ===== ssbg_regs.vh
`ifndef SSBG_REGS_VH
`define SSBG_REGS_VH

// Register addresses on the plain register port.
`define SSBG_ADDR_CONTROL 4'h0
`define SSBG_ADDR_BAUD 4'h1

// Control register fields.
`define SSBG_CTRL_ON_BIT 0

// Reset values.
`define SSBG_RELOAD_RESET 16'h0000
`define SSBG_ZERO16 16'h0000
`define SSBG_ONE16 16'h0001

// Clock and bit-rate ceiling, in kHz.
`define SSBG_CPU_KHZ 32'h0000_C350
`define SSBG_MAX_BAUD_KHZ 32'h0000_1F40

// Arithmetic constants for the rate floor.
`define SSBG_STEP_DIV 32'h0000_0002
`define SSBG_UNIT 32'h0000_0001

`endif

// ===== ssbg_props.sv
`timescale 1ns/100ps
module ssbg_props(
	input wire clk,
	input wire reset_n,
	input wire [3:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire channel_global_on,
	input wire baud_tick
);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
property p_gap; baud_tick |=> !baud_tick; endproperty
a_gap: assert property (p_gap) else $error("tick longer than one cycle");
property p_off; !channel_global_on |=> !baud_tick; endproperty
a_off: assert property (p_off) else $error("tick while off");
property p_rd; !reg_rd |=> reg_rdata == 16'h0000; endproperty
a_rd: assert property (p_rd) else $error("stray read data");
property p_on_set; reg_wr && reg_addr == 4'h0 && reg_wdata[0] |=> channel_global_on; endproperty
a_on_set: assert property (p_on_set) else $error("enable not taken");
property p_on_clr;
	reg_wr && reg_addr == 4'h0 && !reg_wdata[0] |=> !channel_global_on;
endproperty
a_on_clr: assert property (p_on_clr) else $error("disable not taken");
property p_rd_ctl;
	reg_rd && reg_addr == 4'h0 |=> reg_rdata == {15'h0000, $past(channel_global_on)};
endproperty
a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");
property p_spacing; baud_tick |=> (!baud_tick) [*7]; endproperty
a_spacing: assert property (p_spacing) else $error("ticks too close");
c_tick: cover property (baud_tick);
c_rd_on: cover property (reg_rd && reg_addr == 4'h1 && channel_global_on);
c_wr_off: cover property (reg_wr && reg_addr == 4'h1 && !channel_global_on);
endmodule
bind ssbg_baud_gen ssbg_props i_ssbg_props(.*);

// ===== ssbg_baud_gen_tb.sv
`timescale 1ns/100ps
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("Error %0t mismatch", $time); end end
module ssbg_baud_gen_tb;
reg clk = 0, reset_n = 0, wr = 0, rd = 0;
reg [3:0] ad = 4'h0;
reg [15:0] wd = 16'h0000;
wire [15:0] rdat;
wire on, tick;
int bad_count = 0, tests_run = 0, n;
ssbg_baud_gen i_ssbg_baud_gen(.clk(clk), .reset_n(reset_n), .reg_addr(ad), .reg_wdata(wd),
	.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .channel_global_on(on), .baud_tick(tick));
initial forever #10 clk = ~clk;
task w(input [3:0] a, input [15:0] d);
	@(posedge clk) begin ad <= a; wd <= d; wr <= 1; end
	@(posedge clk) wr <= 0;
endtask
task r(input [3:0] a, output [15:0] q);
	@(posedge clk) begin ad <= a; rd <= 1; end
	@(posedge clk) rd <= 0;
	#1 q = rdat;
endtask
task give_verdict;
	$display("ran %0d bad %0d", tests_run, bad_count);
	if (bad_count == 0 && tests_run > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask
// Waits for a tick, then counts the cycles to the next one.
task period(output int m);
	for (m = 0; m < 200 && tick !== 1; m++) @(posedge clk) #1;
	m = 0;
	do begin @(posedge clk) #1; m++; end while (tick !== 1 && m < 200);
endtask
// After reset the channel is off, idle and reads back zero.
task t_idle;
	reg [15:0] q;
	@(posedge clk) #1;
	`CHK(on, 1'b0)
	`CHK(tick, 1'b0)
	r(4'h0, q); `CHK(q, 16'h0000)
	r(4'h1, q); `CHK(q, 16'h0000)
	@(posedge clk) #1; `CHK(rdat, 16'h0000)
	$display("t_idle done");
endtask
// Reload three is the fastest legal setting at this clock: eight cycles per tick.
task t_bd;
	reg [15:0] q;
	int m;
	w(4'h1, 16'h0003);
	r(4'h1, q); `CHK(q, 16'h0003)
	w(4'h0, 16'h0001);
	r(4'h0, q); `CHK(q, 16'h0001)
	period(m); `CHK(m, 8)
	@(posedge clk) #1; `CHK(tick, 1'b0)
	r(4'h1, q); `CHK(q <= 16'h0003, 1'b1)
	w(4'h1, 16'h0009);
	w(4'h0, 16'h0000);
	r(4'h1, q); `CHK(q, 16'h0003)
	w(4'h1, 16'h0007);
	r(4'h1, q); `CHK(q, 16'h0007)
	w(4'h0, 16'h0001);
	period(m); `CHK(m, 16)
	w(4'h0, 16'h0000);
	$display("t_bd done");
endtask
// A reset in mid-run stops the channel and clears the reload.
task t_rst;
	reg [15:0] q;
	w(4'h0, 16'h0001);
	repeat (5) @(posedge clk);
	reset_n <= 0;
	repeat (2) @(posedge clk);
	reset_n <= 1;
	#1 `CHK(on, 1'b0)
	r(4'h1, q); `CHK(q, 16'h0000)
	for (n = 0; n < 20; n++) begin @(posedge clk) #1; `CHK(tick, 1'b0) end
	$display("t_rst done");
endtask
initial begin
	repeat (12) @(posedge clk);
	reset_n <= 1;
	t_idle;
	t_bd;
	t_rst;
	give_verdict;
end
initial begin repeat (2000) @(posedge clk); bad_count++; give_verdict; end
endmodule
